/* asr_pkg.sv */
// Constants and carrier types for the static memory access controller.
package asr_pkg;

  localparam int unsigned CLK_PERIOD_NS     = 100;
  localparam int unsigned ADDR_W            = 17;
  localparam int unsigned DATA_W            = 8;
  localparam int unsigned MEM_WORDS         = 131072;

  localparam int unsigned READ_CYCLE_MIN_NS    = 70;
  localparam int unsigned WRITE_CYCLE_MIN_NS   = 70;
  localparam int unsigned ADDR_TO_DATA_NS      = 70;
  localparam int unsigned OUT_EN_TO_DATA_NS    = 35;
  localparam int unsigned SELECT_TO_END_NS     = 60;
  localparam int unsigned ADDR_TO_END_NS       = 60;
  localparam int unsigned WRITE_DATA_SETUP_NS  = 30;
  localparam int unsigned STROBE_LOW_TO_FLOAT_NS = 25;
  localparam int unsigned STROBE_HIGH_TO_DRIVE_NS = 5;

  function automatic int unsigned cyc_up(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned READ_CYC = cyc_up(ADDR_TO_DATA_NS > READ_CYCLE_MIN_NS
                                            ? ADDR_TO_DATA_NS
                                            : READ_CYCLE_MIN_NS);
  localparam int unsigned STROBE_CYC = cyc_up(
      (SELECT_TO_END_NS > WRITE_DATA_SETUP_NS + STROBE_LOW_TO_FLOAT_NS)
      ? SELECT_TO_END_NS
      : WRITE_DATA_SETUP_NS + STROBE_LOW_TO_FLOAT_NS);
  localparam int unsigned WRITE_CYC = cyc_up(WRITE_CYCLE_MIN_NS);
  localparam int unsigned TURN_CYC  = cyc_up(STROBE_HIGH_TO_DRIVE_NS);
  localparam int unsigned CNT_W     = 4;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] word_address;
    logic [DATA_W-1:0] data;
  } asr_req_t;

  typedef struct packed {
    logic              select_active_low;
    logic              select_active_high;
    logic              out_en_n;
    logic              write_strobe_n;
  } asr_ctl_t;

endpackage

/* asr_sync.sv */
// Two-flop synchroniser for the byte lines read back from the memory.
`timescale 1ns/1ps
module asr_sync #(
  parameter int unsigned WIDTH = 8
) (
  // Clock, reset and enable
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_ce,
  // Data
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      meta_ff <= '0;
      o_q     <= '0;
    end else if (i_ce) begin
      meta_ff <= i_d;
      o_q     <= meta_ff;
    end
  end

endmodule // asr_sync

/* asr_ctrl.sv */
// Host controller that drives an asynchronous byte-wide static memory.
//
// Behaviour
// - Write ends at first deasserting edge.
// - Controller never drives while memory drives.
// - Strobe low at least setup plus float.
// - Read cycle lasts at least 70 ns.
// - Write cycle lasts at least 70 ns.
// - Selects and address held 60 ns before end.
// - Address set on the same edge as write start, held after.
// - Write data set 30 ns before end.
`timescale 1ns/1ps
module asr_ctrl #(
  parameter int unsigned ADDR_W = asr_pkg::ADDR_W,
  parameter int unsigned DATA_W = asr_pkg::DATA_W
) (
  // Clock, reset and enable
  input  wire logic                  I_CORE_CLK,
  input  wire logic                  I_RESETN,
  input  wire logic                  I_CE,
  // Request side
  input  wire logic                  I_REQ_VALID,
  input  wire asr_pkg::asr_req_t     I_REQ,
  output logic                       O_REQ_READY,
  output logic                       O_RD_VALID,
  output logic      [DATA_W-1:0]     O_RD_DATA,
  // Memory pins
  output logic      [ADDR_W-1:0]     O_WORD_ADDRESS,
  output asr_pkg::asr_ctl_t          O_MEM_CTL,
  input  wire logic [DATA_W-1:0]     I_BYTE_LINES,
  output logic      [DATA_W-1:0]     O_BYTE_LINES,
  output logic                       O_BYTE_LINES_OE_N
);

  ////////////////////////////////////////////////////////////////////////////
  // State and counters.

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_WSTROBE,
    ST_WEND,
    ST_TURN
  } asr_state_t;

  localparam logic [asr_pkg::CNT_W-1:0] READ_CNT =
    asr_pkg::CNT_W'(asr_pkg::READ_CYC);
  localparam logic [asr_pkg::CNT_W-1:0] STROBE_CNT =
    asr_pkg::CNT_W'(asr_pkg::STROBE_CYC);
  localparam logic [asr_pkg::CNT_W-1:0] WEND_CNT =
    asr_pkg::CNT_W'(asr_pkg::WRITE_CYC > asr_pkg::STROBE_CYC
                    ? asr_pkg::WRITE_CYC - asr_pkg::STROBE_CYC : 1);
  localparam logic [asr_pkg::CNT_W-1:0] TURN_CNT =
    asr_pkg::CNT_W'(asr_pkg::TURN_CYC);

  asr_state_t                  state_ff;
  asr_state_t                  nxt_state;
  logic [asr_pkg::CNT_W-1:0]   cnt_ff;
  logic [asr_pkg::CNT_W-1:0]   nxt_cnt;
  logic [DATA_W-1:0]           rd_sync;
  logic                        cnt_done;

  assign cnt_done = (cnt_ff == 4'h1);

  asr_sync #(
    .WIDTH (DATA_W)
  ) u_sync (
    .i_clk    (I_CORE_CLK),
    .i_resetn (I_RESETN),
    .i_ce     (I_CE),
    .i_d      (I_BYTE_LINES),
    .o_q      (rd_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = (cnt_ff != 4'h0) ? cnt_ff - 4'h1 : cnt_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (I_REQ_VALID) begin
          nxt_state = I_REQ.write ? ST_WSTROBE : ST_READ;
          // Two synchroniser stages add to the access time.
          nxt_cnt   = I_REQ.write ? STROBE_CNT : READ_CNT + 4'h2;
        end
      end
      ST_READ: begin
        if (cnt_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_WSTROBE: begin
        if (cnt_done) begin
          nxt_state = ST_WEND;
          nxt_cnt   = WEND_CNT;
        end
      end
      ST_WEND: begin
        if (cnt_done) begin
          nxt_state = ST_TURN;
          nxt_cnt   = TURN_CNT;
        end
      end
      ST_TURN: begin
        if (cnt_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 4'h0;
    end else if (I_CE) begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address and write data, latched at request and held past write end.

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      O_WORD_ADDRESS <= '0;
      O_BYTE_LINES   <= '0;
    end else if (I_CE && state_ff == ST_IDLE && I_REQ_VALID) begin
      O_WORD_ADDRESS <= I_REQ.word_address;
      O_BYTE_LINES   <= I_REQ.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory control pins.

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      O_MEM_CTL         <= '{1'b1, 1'b0, 1'b1, 1'b1};
      O_BYTE_LINES_OE_N <= 1'b1;
    end else if (I_CE) begin
      unique case (nxt_state)
        ST_READ: begin
          O_MEM_CTL         <= '{1'b0, 1'b1, 1'b0, 1'b1};
          O_BYTE_LINES_OE_N <= 1'b1;
        end
        ST_WSTROBE: begin
          // Output enable stays high so the memory never drives here.
          O_MEM_CTL         <= '{1'b0, 1'b1, 1'b1, 1'b0};
          O_BYTE_LINES_OE_N <= 1'b0;
        end
        ST_WEND: begin
          // Strobe alone ends the write; data stays driven for hold.
          O_MEM_CTL         <= '{1'b0, 1'b1, 1'b1, 1'b1};
          O_BYTE_LINES_OE_N <= 1'b0;
        end
        default: begin
          O_MEM_CTL         <= '{1'b1, 1'b0, 1'b1, 1'b1};
          O_BYTE_LINES_OE_N <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request handshake and read return.

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      O_REQ_READY <= 1'b0;
      O_RD_VALID  <= 1'b0;
      O_RD_DATA   <= '0;
    end else if (I_CE) begin
      O_REQ_READY <= (nxt_state == ST_IDLE);
      O_RD_VALID  <= (state_ff == ST_READ) && cnt_done;
      if ((state_ff == ST_READ) && cnt_done) begin
        O_RD_DATA <= rd_sync;
      end
    end
  end

endmodule // asr_ctrl

/* asr_mem_model.sv */
// Model of the byte-wide static memory on the far side.
`timescale 1ns/1ps
module asr_mem_model (
  // Clock for the float pattern
  input  wire logic              i_clk,
  // Memory pins
  input  wire logic [16:0]       i_adr,
  input  wire asr_pkg::asr_ctl_t i_ctl,
  input  wire logic [7:0]        i_host,
  input  wire logic              i_host_oe_n,
  output logic      [7:0]        o_lines
);
  logic [7:0] mem [asr_pkg::MEM_WORDS];
  logic       ph = 1'b0;
  logic       sel;
  assign sel = !i_ctl.select_active_low && i_ctl.select_active_high;
  always @(posedge i_clk) ph <= ~ph;
  always @(posedge i_ctl.write_strobe_n) begin
    if (sel) mem[i_adr] = i_host;
  end
  always @* begin
    if (sel && !i_ctl.out_en_n && i_ctl.write_strobe_n)
      o_lines = mem[i_adr];
    else if (!i_host_oe_n)
      o_lines = i_host;
    else
      o_lines = {8{ph}} ^ 8'h5a;
  end
endmodule // asr_mem_model

/* asr_ctrl_chk.sv */
// Concurrent checks on the static memory controller pins.
`timescale 1ns/1ps
module asr_ctrl_chk (
  // Clock, reset and enable
  input wire logic              I_CORE_CLK,
  input wire logic              I_RESETN,
  input wire logic              I_CE,
  // Request side
  input wire logic              I_REQ_VALID,
  input wire logic              O_REQ_READY,
  input wire logic              O_RD_VALID,
  // Memory pins
  input wire logic [16:0]       O_WORD_ADDRESS,
  input wire asr_pkg::asr_ctl_t O_MEM_CTL,
  input wire logic [7:0]        O_BYTE_LINES,
  input wire logic              O_BYTE_LINES_OE_N
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN || !I_CE);
  property p_no_fight;
    !O_BYTE_LINES_OE_N |-> O_MEM_CTL.out_en_n;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("host drives while memory drives");
  property p_strobe_sel;
    !O_MEM_CTL.write_strobe_n |-> !O_MEM_CTL.select_active_low
      && O_MEM_CTL.select_active_high && !O_BYTE_LINES_OE_N;
  endproperty
  a_strobe_sel: assert property (p_strobe_sel)
    else $error("strobe low without select or data");
  property p_strobe_len;
    $fell(O_MEM_CTL.write_strobe_n) |=> O_MEM_CTL.write_strobe_n
      && !O_MEM_CTL.select_active_low;
  endproperty
  a_strobe_len: assert property (p_strobe_len)
    else $error("strobe not ended first after one cycle");
  property p_wr_hold;
    !O_MEM_CTL.write_strobe_n |=> $stable(O_WORD_ADDRESS)
      && $stable(O_BYTE_LINES) && !O_BYTE_LINES_OE_N;
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("address or data moved at write end");
  property p_wr_end;
    $rose(O_MEM_CTL.write_strobe_n) |=> O_MEM_CTL.select_active_low
      && O_BYTE_LINES_OE_N;
  endproperty
  a_wr_end: assert property (p_wr_end)
    else $error("write cycle not closed");
  property p_rd_len;
    $fell(O_MEM_CTL.out_en_n) |-> !O_MEM_CTL.out_en_n[*3]
      ##1 O_MEM_CTL.out_en_n;
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read enable length wrong");
  property p_rd_adr;
    $fell(O_MEM_CTL.out_en_n) |=> $stable(O_WORD_ADDRESS)[*3];
  endproperty
  a_rd_adr: assert property (p_rd_adr)
    else $error("address moved during read");
  property p_rd_ans;
    $fell(O_MEM_CTL.out_en_n) |-> ##3 O_RD_VALID && O_REQ_READY;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read answer late or early");
  property p_take;
    O_REQ_READY && I_REQ_VALID |=> !O_REQ_READY;
  endproperty
  a_take: assert property (p_take)
    else $error("ready stayed high after take");
  c_wr: cover property ($fell(O_MEM_CTL.write_strobe_n));
  c_rd: cover property (O_RD_VALID);
  c_take: cover property (O_REQ_READY && I_REQ_VALID);
endmodule // asr_ctrl_chk

/* asr_ctrl_test.sv */
// Self-checking bench for the static memory controller.
`timescale 1ns/1ps
module asr_ctrl_test;
  logic              clk;
  logic              rst_n;
  logic              ce;
  logic              vld;
  asr_pkg::asr_req_t req;
  logic              rdy;
  logic              rd_vld;
  logic              oe_n;
  logic              w;
  logic [7:0]        rd_dat;
  logic [7:0]        din;
  logic [7:0]        dout;
  logic [16:0]       adr;
  logic [16:0]       a;
  asr_pkg::asr_ctl_t ctl;
  int                n_mismatch = 0;
  int                checked = 0;
  int                cyc = 0;
  logic [31:0]       seed = 32'h0000005c;
  logic [7:0]        ref_mem [int];
  logic [7:0]        exp_q [$];
  asr_ctrl dut (.I_CORE_CLK(clk), .I_RESETN(rst_n), .I_CE(ce),
    .I_REQ_VALID(vld), .I_REQ(req), .O_REQ_READY(rdy),
    .O_RD_VALID(rd_vld), .O_RD_DATA(rd_dat), .O_WORD_ADDRESS(adr),
    .O_MEM_CTL(ctl), .I_BYTE_LINES(din), .O_BYTE_LINES(dout),
    .O_BYTE_LINES_OE_N(oe_n));
  asr_mem_model mem (.i_clk(clk), .i_adr(adr), .i_ctl(ctl),
    .i_host(dout), .i_host_oe_n(oe_n), .o_lines(din));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic issue(input logic wr, input logic [16:0] ad,
                       input logic [7:0] d);
    int t;
    t = 0;
    vld <= 1'b1;
    req <= '{write: wr, word_address: ad, data: d};
    @(negedge clk);
    while (rdy !== 1'b1 && t < 50) begin
      @(negedge clk);
      t++;
    end
    if (t == 50)
      n_mismatch++;
    @(posedge clk);
    if (wr)
      ref_mem[ad] = d;
    else
      exp_q.push_back(ref_mem[ad]);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (rd_vld === 1'b1 && exp_q.size() == 0)
      n_mismatch++;
    else if (rd_vld === 1'b1)
      chk(rd_dat, exp_q.pop_front());
    if (cyc == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    vld = 1'b0;
    ce = 1'b1;
    req = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({4'h0, ctl}, 8'h0b);
    for (int i = 0; i < 300; i++) begin
      seed = xorshift(seed);
      a = seed[3] ? 17'h1ffff : {13'h0000, seed[7:4]};
      w = seed[0] || !ref_mem.exists(a);
      issue(w, a, seed[15:8]);
      if (seed[18:16] == 3'h0) begin
        // Freeze the controller for one edge in mid-transfer.
        ce <= 1'b0;
        @(posedge clk);
        ce <= 1'b1;
      end
    end
    vld <= 1'b0;
    repeat (8) @(posedge clk);
    chk(8'(exp_q.size()), 8'h00);
    finish_test();
  end
endmodule // asr_ctrl_test
bind asr_ctrl asr_ctrl_chk chk (.I_CORE_CLK(I_CORE_CLK),
  .I_RESETN(I_RESETN), .I_CE(I_CE), .I_REQ_VALID(I_REQ_VALID),
  .O_REQ_READY(O_REQ_READY), .O_RD_VALID(O_RD_VALID),
  .O_WORD_ADDRESS(O_WORD_ADDRESS), .O_MEM_CTL(O_MEM_CTL),
  .O_BYTE_LINES(O_BYTE_LINES), .O_BYTE_LINES_OE_N(O_BYTE_LINES_OE_N));
